// file: verilog/mmes_top.sv
// Monitor mode entry select: decision, clock choice, watchdog, serial pin
`timescale 1ns/1ps
module mmes_top import mmes_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic por_n_i,
	input wire logic test_high_voltage_i,
	input wire logic irq_pin_i,
	input wire logic reset_high_voltage_i,
	input wire logic [7:0] vector_hi_byte_i,
	input wire logic [7:0] vector_lo_byte_i,
	input wire logic entry_strap_pin_one_i,
	input wire logic entry_strap_pin_two_i,
	input wire logic divider_select_pin_i,
	input wire logic loop_clock_en_i,
	input wire logic monitor_serial_pin_i,
	output logic monitor_serial_pin_o,
	output logic monitor_serial_pin_oe_o,
	output logic monitor_mode_o,
	output logic serial_comm_o,
	output logic oscillator_bypass_o,
	output logic base_clock_select_o,
	output logic watchdog_disable_o,
	output logic bus_clk_en_o,
	output logic baud_tick_o,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);
	mmes_cap_type cap_q;
	mmes_mode_type mode_q;
	mmes_mode_type mode_d;
	logic vector_blank;
	logic blank_q;
	logic serial_q;
	logic divsel_q;
	logic straps_ok_q;
	logic hv_entry_q;
	logic sticky_blank_q;
	logic [15:0] vector_q;
	logic capture;
	logic held;
	logic monitor;
	logic wdog_off_q;
	logic [1:0] ctrl_q;
	logic wr_ctrl;
	logic [31:0] wr_data;
	logic [31:0] status_word;
	logic div_run;
	logic div_tick;
	logic [8:0] div_ratio;
	logic bus_en;
	logic baud_en;

	// Blank means both vector bytes still hold the erased pattern
	// RQ1: blank vector test
	assign vector_blank = (vector_hi_byte_i == MMES_BLANK_BYTE) &&
		(vector_lo_byte_i == MMES_BLANK_BYTE);

	// Entry decision from the live pins, only used on the capture edge
	always_comb begin
		mode_d = MMES_MODE_USER;
		// RQ11: high voltage wins
		if (test_high_voltage_i) begin
			mode_d = MMES_MODE_MON_HV;
		end else if (vector_blank && !reset_high_voltage_i) begin
			// RQ5: interrupt high
			// RQ6: interrupt low
			mode_d = irq_pin_i ? MMES_MODE_MON_VDD : MMES_MODE_MON_LOOP;
		end
	end

	// Sequencer: waits for the first edge after reset release, then holds
	// RQ15: latch at release
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap_q <= MMES_ST_WAIT;
		end else begin
			case (cap_q)
				MMES_ST_WAIT: cap_q <= MMES_ST_HELD;
				MMES_ST_HELD: cap_q <= MMES_ST_HELD;
				default: cap_q <= MMES_ST_WAIT;
			endcase
		end
	end

	assign capture = (cap_q == MMES_ST_WAIT);
	assign held = (cap_q == MMES_ST_HELD);

	// A pin reset does not leave a blank-vector monitor session;
	// only a power-on reset clears this flag, so it has its own reset
	// RQ14: power-on decision
	always_ff @(posedge clk_sys_i or negedge por_n_i) begin
		if (!por_n_i) begin
			sticky_blank_q <= 1'b0;
		end else if (capture && (mode_d == MMES_MODE_MON_VDD ||
			mode_d == MMES_MODE_MON_LOOP) && !sticky_blank_q) begin
			sticky_blank_q <= 1'b1;
		end
	end

	// Mode held once per reset; a sticky session skips capture and leaves mode_q at user
	// RQ17: hold entry mode
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= MMES_MODE_USER;
		end else if (capture && !sticky_blank_q) begin
			mode_q <= mode_d;
		end
	end

	// Sticky session must survive the pin reset that clears mode_q
	always_ff @(posedge clk_sys_i or negedge por_n_i) begin
		if (!por_n_i) begin
			hv_entry_q <= 1'b0;
		end else if (capture && !sticky_blank_q) begin
			hv_entry_q <= (mode_d == MMES_MODE_MON_LOOP);
		end
	end

	// Remaining entry levels held together with the mode
	// RQ17: hold pin levels
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			blank_q <= 1'b0;
			serial_q <= 1'b0;
			divsel_q <= 1'b0;
			straps_ok_q <= 1'b0;
			vector_q <= 16'h0000;
		end else if (capture) begin
			blank_q <= vector_blank;
			// RQ9: serial pin choice
			serial_q <= monitor_serial_pin_i;
			divsel_q <= divider_select_pin_i;
			// RQ8: host strap levels
			straps_ok_q <= !entry_strap_pin_two_i && entry_strap_pin_one_i;
			vector_q <= {vector_hi_byte_i, vector_lo_byte_i};
		end
	end

	// Effective mode: a sticky blank session restores its own mode
	always_comb begin
		if (held && sticky_blank_q && mode_q == MMES_MODE_USER) begin
			monitor = 1'b1;
		end else begin
			monitor = held && (mode_q != MMES_MODE_USER);
		end
	end

	// Watchdog control; off throughout reset and until the mode is held
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// RQ10: watchdog off in reset
			wdog_off_q <= 1'b1;
		end else if (!held) begin
			wdog_off_q <= 1'b1;
		end else if (sticky_blank_q) begin
			// RQ16: blank entry always off
			wdog_off_q <= 1'b1;
		end else if (mode_q == MMES_MODE_MON_HV) begin
			wdog_off_q <= test_high_voltage_i | reset_high_voltage_i;
		end else begin
			wdog_off_q <= 1'b0;
		end
	end

	// Clock source and ratio; the loop path counts loop ticks, not cycles
	// RQ7: divider pin ignored
	always_comb begin
		div_tick = 1'b1;
		div_ratio = MMES_DIV_FOUR;
		if (monitor && mode_q == MMES_MODE_MON_HV) begin
			// RQ2: two or four
			div_ratio = divsel_q ? MMES_DIV_FOUR : MMES_DIV_TWO;
		end else if (monitor && (mode_q == MMES_MODE_MON_LOOP ||
			(sticky_blank_q && hv_entry_q))) begin
			// RQ6: loop clock source
			div_tick = loop_clock_en_i;
		end
	end

	// No bus clock at all before the mode is held
	// RQ10: no bus clock
	assign div_run = held;

	mmes_divider u_bus_div (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.run_i(div_run),
		.tick_i(div_tick),
		.ratio_i(div_ratio),
		.pulse_o(bus_en)
	);

	// Every entry set yields the same bus rate, so one ratio gives 9600
	// RQ14: fixed baud
	mmes_divider u_baud_div (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.run_i(monitor & serial_q & ctrl_q[MMES_CTRL_BAUD_EN_BIT]),
		.tick_i(bus_en),
		.ratio_i(MMES_BAUD_DIV),
		.pulse_o(baud_en)
	);

	// Control register written by software over the bus
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= MMES_CONTROL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= wr_data[1:0];
		end
	end

	// Open-drain drive: only ever pull low, the pullup makes the mark
	// RQ12: pull low only
	// RQ13: NRZ bit levels
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			monitor_serial_pin_oe_o <= 1'b0;
		end else begin
			monitor_serial_pin_oe_o <= monitor & serial_q & ctrl_q[MMES_CTRL_TX_LOW_BIT];
		end
	end

	assign monitor_serial_pin_o = 1'b0;

	// Registered mode outputs
	// RQ4: bypass on high voltage
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			monitor_mode_o <= 1'b0;
			serial_comm_o <= 1'b0;
			oscillator_bypass_o <= 1'b0;
			base_clock_select_o <= 1'b0;
		end else begin
			monitor_mode_o <= monitor;
			serial_comm_o <= monitor & serial_q;
			oscillator_bypass_o <= monitor && (mode_q == MMES_MODE_MON_HV);
			// RQ5: loop stays off
			base_clock_select_o <= monitor && (mode_q == MMES_MODE_MON_LOOP ||
				(sticky_blank_q && hv_entry_q));
		end
	end

	assign watchdog_disable_o = wdog_off_q;
	assign bus_clk_en_o = bus_en;
	assign baud_tick_o = baud_en;

	// Status word gathers the held decision and live pin level
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[MMES_ST_MODE_LSB +: 2] = mode_q;
		status_word[MMES_ST_MONITOR_BIT] = monitor;
		status_word[MMES_ST_SERIAL_BIT] = serial_q;
		status_word[MMES_ST_BLANK_BIT] = blank_q;
		status_word[MMES_ST_STRAPS_BIT] = straps_ok_q;
		status_word[MMES_ST_DIVSEL_BIT] = divsel_q;
		status_word[MMES_ST_WDOG_OFF_BIT] = wdog_off_q;
		status_word[MMES_ST_PIN_BIT] = monitor_serial_pin_i;
		status_word[MMES_ST_HELD_BIT] = held;
		status_word[MMES_ST_STICKY_BIT] = sticky_blank_q;
	end

	mmes_ahb_slave u_bus (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(hsize_i),
		.hwdata_i(hwdata_i),
		.hready_i(hready_i),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.status_i(status_word),
		.control_i({30'h0000_0000, ctrl_q}),
		.vector_i({16'h0000, vector_q}),
		.wr_ctrl_o(wr_ctrl),
		.wr_data_o(wr_data)
	);
endmodule

// file: verilog/mmes_pkg.sv
// Constants and types for the monitor mode entry select block
// Function
// RQ1: Both vector bytes all ones means blank
// RQ2: High-voltage entry: divider pin picks two/four
// RQ3: Host supplies matching oscillator for high voltage
// RQ4: High-voltage entry bypasses crystal oscillator
// RQ5: Blank, interrupt high: loop off, divide four
// RQ6: Blank, interrupt low: loop on, base select
// RQ7: Low-voltage entry ignores straps and divider pin
// RQ8: Host sets strap pins and serial pin
// RQ9: Serial pin high selects serial, else parallel
// RQ10: In reset: no clock, watchdog off
// RQ11: Programmed vector needs high voltage, else user
// RQ12: Single wired-OR pin, only pull low
// RQ13: Standard mark/space NRZ framing on pin
// RQ14: Decide after power-on; every entry gives 9600
// RQ15: Mode latched at reset release edge
// RQ16: Blank-vector monitor keeps watchdog always off
// RQ17: Entry conditions held once per reset
package mmes_pkg;

	// Reset vector blank pattern, one byte of each vector half
	localparam logic [7:0] MMES_BLANK_BYTE = 8'hff;

	// Register byte offsets on the bus, low address byte decoded
	localparam logic [7:0] MMES_STATUS_OFS = 8'h00;
	localparam logic [7:0] MMES_CONTROL_OFS = 8'h04;
	localparam logic [7:0] MMES_VECTOR_OFS = 8'h08;

	// Control register fields and value after reset
	localparam int MMES_CTRL_TX_LOW_BIT = 0;
	localparam int MMES_CTRL_BAUD_EN_BIT = 1;
	localparam logic [1:0] MMES_CONTROL_RST = 2'h2;

	// Status register field positions
	localparam int MMES_ST_MODE_LSB = 0;
	localparam int MMES_ST_MONITOR_BIT = 2;
	localparam int MMES_ST_SERIAL_BIT = 3;
	localparam int MMES_ST_BLANK_BIT = 4;
	localparam int MMES_ST_STRAPS_BIT = 5;
	localparam int MMES_ST_DIVSEL_BIT = 6;
	localparam int MMES_ST_WDOG_OFF_BIT = 7;
	localparam int MMES_ST_PIN_BIT = 8;
	localparam int MMES_ST_HELD_BIT = 9;
	localparam int MMES_ST_STICKY_BIT = 10;

	// Clock rates for the monitor link
	localparam int MMES_BUS_HZ = 2457600;
	localparam int MMES_BAUD = 9600;
	localparam int MMES_SLOW_OSC_HZ = 4915200;
	localparam int MMES_FAST_OSC_HZ = 9830400;
	localparam int MMES_CRYSTAL_HZ = 32768;

	// Divider ratios, in cycles of the source tick
	localparam logic [8:0] MMES_DIV_TWO = 9'h002;
	localparam logic [8:0] MMES_DIV_FOUR = 9'h004;
	localparam logic [8:0] MMES_BAUD_DIV = 9'(MMES_BUS_HZ / MMES_BAUD);

	// Entry decision held once per reset
	typedef enum logic [1:0] {
		MMES_MODE_USER = 2'b00,
		MMES_MODE_MON_HV = 2'b01,
		MMES_MODE_MON_VDD = 2'b10,
		MMES_MODE_MON_LOOP = 2'b11
	} mmes_mode_type;

	// Capture sequencer
	typedef enum logic [0:0] {
		MMES_ST_WAIT = 1'b0,
		MMES_ST_HELD = 1'b1
	} mmes_cap_type;

endpackage

// file: verilog/mmes_divider.sv
// Enable pulse divider counting ticks of a source enable
`timescale 1ns/1ps
module mmes_divider import mmes_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic tick_i,
	input wire logic [8:0] ratio_i,
	output logic pulse_o
);
	logic [8:0] count_q;
	logic wrap;

	assign wrap = (count_q >= ratio_i - 9'h001);

	// Counter restarts whenever run drops, so a new ratio starts clean
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q <= 9'h000;
		end else if (!run_i) begin
			count_q <= 9'h000;
		end else if (tick_i) begin
			count_q <= wrap ? 9'h000 : count_q + 9'h001;
		end
	end

	// One-cycle pulse on the last tick of each period
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pulse_o <= 1'b0;
		end else begin
			pulse_o <= run_i & tick_i & wrap;
		end
	end
endmodule

// file: verilog/mmes_ahb_slave.sv
// AHB-Lite slave front end with zero wait states
`timescale 1ns/1ps
module mmes_ahb_slave import mmes_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [31:0] status_i,
	input wire logic [31:0] control_i,
	input wire logic [31:0] vector_i,
	output logic wr_ctrl_o,
	output logic [31:0] wr_data_o
);
	logic take;
	logic wr_pend_q;
	logic [31:0] rd_mux;

	// Only whole-word, non-idle transfers to this slave are taken
	assign take = hsel_i & htrans_i[1] & hready_i & (hsize_i == 3'h2);
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign wr_ctrl_o = wr_pend_q;
	assign wr_data_o = hwdata_i;

	// Unmapped offsets read as zero
	always_comb begin
		case (haddr_i[7:0])
			MMES_STATUS_OFS: rd_mux = status_i;
			MMES_CONTROL_OFS: rd_mux = control_i;
			MMES_VECTOR_OFS: rd_mux = vector_i;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Write lands in the data phase, when hwdata is valid
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= take & hwrite_i & (haddr_i[7:0] == MMES_CONTROL_OFS);
		end
	end

	// Read data sampled at the address phase and held through the data phase
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (take & !hwrite_i) begin
			hrdata_o <= rd_mux;
		end
	end
endmodule

// file: bench/mmes_host_model.sv
// Host side of the single-wire monitor link behind the level shifter
`timescale 1ns/1ps
module mmes_host_model (
	input wire logic clk_sys_i,
	input wire logic hold_low_i,
	output logic pull_low_o
);
	logic tx_low = 1'b0;
	// pull low only
	// The pullup gives the high level, so the host never drives a one
	assign pull_low_o = hold_low_i | tx_low;
	// NRZ mark space
	// Start bit, eight data bits first bit lowest, stop bit; slow hosts pass more cycles
	task automatic send_frame(input logic [7:0] b, input int bit_cycles);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			tx_low <= !f[i];
			repeat (bit_cycles) @(posedge clk_sys_i);
		end
		tx_low <= 1'b0;
	endtask
endmodule

// file: bench/mmes_checker.sv
// Port assertions for the monitor mode entry select block
`timescale 1ns/1ps
module mmes_checker (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic test_high_voltage_i,
	input wire logic reset_high_voltage_i,
	input wire logic monitor_serial_pin_o,
	input wire logic monitor_serial_pin_oe_o,
	input wire logic monitor_mode_o,
	input wire logic serial_comm_o,
	input wire logic oscillator_bypass_o,
	input wire logic base_clock_select_o,
	input wire logic watchdog_disable_o,
	input wire logic bus_clk_en_o
);
	logic [1:0] up_q;
	// Edges since release, saturating; mode outputs are settled from the fourth edge
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up_q <= 2'h0;
		end else if (up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	// Reset is the cause here, so this one is never disabled
	property p_in_reset;
		disable iff (1'b0) !rst_n_i |-> watchdog_disable_o && !bus_clk_en_o && !monitor_mode_o;
	endproperty
	a_in_reset: assert property (p_in_reset) else $error("outputs active in reset");
	property p_bypass;
		oscillator_bypass_o |-> monitor_mode_o && !base_clock_select_o;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass outside high voltage");
	property p_loop;
		base_clock_select_o |-> monitor_mode_o && !oscillator_bypass_o;
	endproperty
	a_loop: assert property (p_loop) else $error("loop select in wrong mode");
	property p_user_wdog;
		up_q == 2'h3 && !monitor_mode_o |-> !watchdog_disable_o;
	endproperty
	a_user_wdog: assert property (p_user_wdog) else $error("watchdog off in user mode");
	property p_hv_wdog;
		up_q == 2'h3 && oscillator_bypass_o && !$past(test_high_voltage_i)
			&& !$past(reset_high_voltage_i) |-> !watchdog_disable_o;
	endproperty
	a_hv_wdog: assert property (p_hv_wdog) else $error("watchdog held off without voltage");
	property p_latched;
		up_q == 2'h3 |-> $stable(monitor_mode_o) && $stable(oscillator_bypass_o)
			&& $stable(base_clock_select_o) && $stable(serial_comm_o);
	endproperty
	a_latched: assert property (p_latched) else $error("mode moved after latching");
	property p_pulse;
		bus_clk_en_o |=> !bus_clk_en_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("bus enable faster than half rate");
	property p_oe;
		monitor_serial_pin_oe_o |-> !monitor_serial_pin_o && monitor_mode_o && serial_comm_o;
	endproperty
	a_oe: assert property (p_oe) else $error("line driven outside serial monitor");
	c_hv: cover property (oscillator_bypass_o && bus_clk_en_o);
	c_loop: cover property (base_clock_select_o && bus_clk_en_o);
	c_oe: cover property (monitor_serial_pin_oe_o);
endmodule
bind mmes_top mmes_checker mmes_checker_i (.clk_sys_i, .rst_n_i, .test_high_voltage_i,
	.reset_high_voltage_i, .monitor_serial_pin_o, .monitor_serial_pin_oe_o, .monitor_mode_o,
	.serial_comm_o, .oscillator_bypass_o, .base_clock_select_o, .watchdog_disable_o,
	.bus_clk_en_o);

// file: bench/testbench.sv
// Self-checking bench for monitor mode entry select
`timescale 1ns/1ps
module testbench import mmes_pkg::*;
;
	// Resets start high so the first drive low is a real falling edge for the async reset
	logic clk_sys_i = 1'b0, rst_n_i = 1'b1, por_n_i = 1'b1, test_high_voltage_i = 1'b0;
	logic irq_pin_i = 1'b1, reset_high_voltage_i = 1'b0, entry_strap_pin_one_i = 1'b1;
	logic entry_strap_pin_two_i = 1'b0, divider_select_pin_i = 1'b0, loop_clock_en_i = 1'b0;
	logic hsel_i = 1'b0, hwrite_i = 1'b0, host_hold = 1'b0, host_pull;
	logic [7:0] vector_hi_byte_i = 8'hff, vector_lo_byte_i = 8'hff;
	logic [1:0] htrans_i = 2'h0, lcnt_q = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
	logic monitor_serial_pin_i, monitor_serial_pin_o, monitor_serial_pin_oe_o, monitor_mode_o;
	logic serial_comm_o, oscillator_bypass_o, base_clock_select_o, watchdog_disable_o;
	logic bus_clk_en_o, baud_tick_o, hready_i, hreadyout_o, hresp_o;
	int err_count = 0, checked = 0, n;

	mmes_top mmes_top_i (.clk_sys_i, .rst_n_i, .por_n_i, .test_high_voltage_i, .irq_pin_i,
		.reset_high_voltage_i, .vector_hi_byte_i, .vector_lo_byte_i, .entry_strap_pin_one_i,
		.entry_strap_pin_two_i, .divider_select_pin_i, .loop_clock_en_i, .monitor_serial_pin_i,
		.monitor_serial_pin_o, .monitor_serial_pin_oe_o, .monitor_mode_o, .serial_comm_o,
		.oscillator_bypass_o, .base_clock_select_o, .watchdog_disable_o, .bus_clk_en_o,
		.baud_tick_o, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i,
		.hrdata_o, .hreadyout_o, .hresp_o);
	mmes_host_model mmes_host_model_i (.clk_sys_i, .hold_low_i(host_hold), .pull_low_o(host_pull));

	// host oscillator
	// One clock stands for every oscillator choice; ratios are checked in cycles
	always #5 clk_sys_i = ~clk_sys_i;
	// Wired line: pullup, low when either side pulls
	assign monitor_serial_pin_i = !host_pull & (!monitor_serial_pin_oe_o | monitor_serial_pin_o);
	assign hready_i = hreadyout_o;
	// Loop output pulses every third cycle
	always @(posedge clk_sys_i) begin
		lcnt_q <= (lcnt_q == 2'h2) ? 2'h0 : lcnt_q + 2'h1;
		loop_clock_en_i <= (lcnt_q == 2'h2);
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Bounded wait for the bus ready sample
	task automatic wait_ready();
		int t;
		t = 0;
		do begin
			@(posedge clk_sys_i);
			t++;
		end while (hready_i !== 1'b1 && t < 50);
		if (hready_i !== 1'b1) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, hready_i, 1'b1);
		end
	endtask
	// Baud ticks seen over more than one full baud period
	task automatic count_baud(output int c);
		c = 0;
		repeat (1100) begin
			@(posedge clk_sys_i);
			if (baud_tick_o) c++;
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= a;
		hwrite_i <= wr;
		wait_ready();
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		wait_ready();
		r = hrdata_o;
	endtask
	// Cycles from one pulse to the next, bus enable or baud tick
	task automatic meas(input logic b, output int c);
		int t;
		t = 0;
		while ((b ? baud_tick_o : bus_clk_en_o) !== 1'b1 && t < 5000) begin
			@(posedge clk_sys_i);
			t++;
		end
		c = 0;
		do begin
			@(posedge clk_sys_i);
			c++;
		end while ((b ? baud_tick_o : bus_clk_en_o) !== 1'b1 && c < 5000);
	endtask
	task automatic run_case(input logic thv, irq, rhv, input logic [15:0] vec, input logic div,
		input logic ser, input mmes_mode_type mode, input int per);
		logic mon;
		logic blank_mon;
		mon = (mode != MMES_MODE_USER);
		blank_mon = (mode == MMES_MODE_MON_VDD) || (mode == MMES_MODE_MON_LOOP);
		por_n_i <= 1'b0;
		rst_n_i <= 1'b0;
		test_high_voltage_i <= thv;
		irq_pin_i <= irq;
		reset_high_voltage_i <= rhv;
		{vector_hi_byte_i, vector_lo_byte_i} <= vec;
		divider_select_pin_i <= div;
		host_hold <= !ser;
		entry_strap_pin_two_i <= !thv;
		entry_strap_pin_one_i <= thv;
		repeat (6) @(posedge clk_sys_i);
		chk(watchdog_disable_o, 1'b1);
		chk(bus_clk_en_o, 1'b0);
		por_n_i <= 1'b1;
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		// Entry pins move after latching and must not matter
		divider_select_pin_i <= !div;
		irq_pin_i <= !irq;
		{vector_hi_byte_i, vector_lo_byte_i} <= ~vec;
		host_hold <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		chk(monitor_mode_o, mon);
		chk(oscillator_bypass_o, mode == MMES_MODE_MON_HV);
		chk(base_clock_select_o, mode == MMES_MODE_MON_LOOP);
		chk(watchdog_disable_o, mon);
		if (mon) chk(serial_comm_o, ser);
		ahb(1'b0, 32'h0, 32'h0, rd);
		chk(rd[10:0], {blank_mon, 2'h3, mon, div, thv, vec == 16'hffff, ser, mon, mode});
		chk(hresp_o, 1'b0);
		meas(1'b0, n);
		chk(n, per);
		// Baud runs only for a serial monitor session
		if (mon && ser) begin
			meas(1'b1, n);
			chk(n, per * 256);
		end else begin
			count_baud(n);
			chk(n, 0);
		end
	endtask

	task automatic finish_test();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		run_case(1'b1, 1'b1, 1'b0, 16'h1234, 1'b0, 1'b1, MMES_MODE_MON_HV, 2);
		// Watchdog follows the live high voltage after this entry
		test_high_voltage_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		chk(watchdog_disable_o, 1'b0);
		reset_high_voltage_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		chk(watchdog_disable_o, 1'b1);
		run_case(1'b1, 1'b0, 1'b0, 16'h1234, 1'b1, 1'b1, MMES_MODE_MON_HV, 4);
		// Control reset value, line drive, unmapped read, host frame seen live
		ahb(1'b0, {24'h0, MMES_CONTROL_OFS}, 32'h0, rd);
		chk(rd, 32'h2);
		ahb(1'b1, {24'h0, MMES_CONTROL_OFS}, 32'h3, rd);
		repeat (2) @(posedge clk_sys_i);
		chk(monitor_serial_pin_i, 1'b0);
		// Line released and baud enable cleared together
		ahb(1'b1, {24'h0, MMES_CONTROL_OFS}, 32'h0, rd);
		ahb(1'b0, 32'hc0, 32'h0, rd);
		chk(rd, 32'h0);
		fork
			mmes_host_model_i.send_frame(8'h00, 40);
		join_none
		repeat (5) @(posedge clk_sys_i);
		ahb(1'b0, 32'h0, 32'h0, rd);
		chk(rd[8], 1'b0);
		count_baud(n);
		chk(n, 0);
		run_case(1'b0, 1'b1, 1'b0, 16'hffff, 1'b0, 1'b0, MMES_MODE_MON_VDD, 4);
		// Pin reset alone keeps a blank-vector session
		vector_hi_byte_i <= 8'h12;
		rst_n_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk(monitor_mode_o, 1'b1);
		run_case(1'b0, 1'b0, 1'b0, 16'hffff, 1'b1, 1'b1, MMES_MODE_MON_LOOP, 12);
		run_case(1'b0, 1'b1, 1'b0, 16'h00ff, 1'b0, 1'b1, MMES_MODE_USER, 4);
		run_case(1'b0, 1'b0, 1'b0, 16'hff00, 1'b0, 1'b1, MMES_MODE_USER, 4);
		run_case(1'b0, 1'b1, 1'b1, 16'hffff, 1'b1, 1'b1, MMES_MODE_USER, 4);
		finish_test();
	end
	// Watchdog on the whole run, well past the expected length
	initial begin
		repeat (80000) @(posedge clk_sys_i);
		err_count++;
		finish_test();
	end
endmodule
